// [hdl/tgd_regs.svh]
`ifndef TGD_REGS_SVH
`define TGD_REGS_SVH
// prescaler and divider geometry
`define TGD_PRE_STAGES 2
`define TGD_DIV_STAGES 21
`define TGD_LOW_STAGES 6
// machine cycle
`define TGD_STATE_LAST 2'h3
`define TGD_MIN_CYCLES 4'h1
`define TGD_MAX_CYCLES 4'hA
// divider taps, 1-based stage numbers
`define TGD_TMR_TAP 3
`define TGD_DVO_TAP 13
`define TGD_TBT_TAP 15
`define TGD_WDT_TAP 18
`define TGD_WARMUP_TAP 16
// reset values
`define TGD_CTRL_RST 4'h0
`endif

// [hdl/tgd_pkg.sv]
package tgd_pkg;
  typedef enum logic [2:0] {
    high_speed_run_single,
    high_speed_run_dual,
    low_speed_run_osc_on,
    low_speed_run_osc_off,
    low_speed_sleep_osc_on,
    low_speed_sleep_osc_off,
    stop_halt,
    stop_warmup
  } tgd_mode_t;

  typedef struct packed {
    logic high_osc_en;
    logic low_osc_en;
    logic core_clock_source_select;
    logic seventh_stage_source_select;
  } tgd_ctrl_t;

  typedef struct packed {
    logic timer_src;
    logic time_base_src;
    logic watchdog_src;
    logic warmup_src;
  } tgd_taps_t;
endpackage

// [hdl/tgd_edge_tick.sv]
`timescale 1ns/10ps
// one-cycle tick on each rising edge of a sampled basic clock
module tgd_edge_tick (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic clk_lvl_i,
  input  wire logic enable_i,
  output logic      tick_o
);
  logic prev;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      // follow the pin in reset so a running oscillator gives no false edge on release
      prev <= clk_lvl_i;
    end else begin
      prev <= clk_lvl_i;
    end
  end

  assign tick_o = enable_i & clk_lvl_i & ~prev;
endmodule

// [hdl/tgd_divider.sv]
`timescale 1ns/10ps
`include "tgd_regs.svh"
// prescaler plus divider chain; stage 7 input chosen by the caller
module tgd_divider #(
  parameter int PRE    = `TGD_PRE_STAGES,
  parameter int LOW    = `TGD_LOW_STAGES,
  parameter int STAGES = `TGD_DIV_STAGES
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              clear_i,
  input  wire logic              fc_tick_i,
  input  wire logic              fs_tick_i,
  input  wire logic              low_run_i,
  input  wire logic              use_fs_i,
  output logic [STAGES-1:0]      stage_o,
  output logic                   s6_carry_o
);
  logic [PRE-1:0]        pre;
  logic [LOW-1:0]        low_q;
  logic [STAGES-LOW-1:0] high_q;
  logic                  pre_carry;
  logic                  s7_in;

  assign pre_carry  = fc_tick_i & low_run_i & (&pre);
  assign s6_carry_o = pre_carry & (&low_q);
  assign s7_in      = use_fs_i ? fs_tick_i : s6_carry_o;
  assign stage_o    = {high_q, low_q};

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || clear_i) begin
      pre <= '0;
    end else if (fc_tick_i && low_run_i) begin
      pre <= pre + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || clear_i) begin
      low_q <= '0;
    end else if (pre_carry) begin
      low_q <= low_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i || clear_i) begin
      high_q <= '0;
    end else if (s7_in) begin
      high_q <= high_q + 1'b1;
    end
  end
endmodule

// [hdl/tgd_timing_gen.sv]
// Contract
// - the generator is a two-stage prescaler feeding a 21-stage divider, plus clock and cycle counters.
// - all prescaler and divider stages clear to zero on reset and on STOP entry and release.
// - the stage 7 input depends on operating mode, core clock select and the stage 7 path select.
// - in low-speed run and sleep modes the low-frequency clock always feeds stage 7.
// - during warm-up after a STOP entered from high-speed run, stage 6 always feeds stage 7.
// - a machine cycle is four states 0 to 3, each one main system clock long.
// - instructions take one to ten machine cycles.
// - instruction execution and peripherals advance on the main system clock tick.
// - divider taps give the divider pulse, time base, watchdog, timer and warm-up sources; the main clock comes from the oscillator ticks.
// - oscillators start and stop and the core clock switches across single, dual and STOP modes.
// - there are two basic clock sources, high and low frequency, each resonator or external clock.
// - in single clock mode the main clock comes from the high-frequency source.
// - in dual clock mode the core clock select moves the core to low frequency and back.
`timescale 1ns/10ps
`include "tgd_regs.svh"
module tgd_timing_gen #(
  parameter int STAGES = `TGD_DIV_STAGES
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              high_freq_osc_in_i,
  input  wire logic              low_freq_osc_in_i,
  input  wire tgd_pkg::tgd_ctrl_t ctrl_i,
  input  wire logic              stop_req_i,
  input  wire logic              stop_release_i,
  input  wire logic              sleep_req_i,
  input  wire logic              wake_i,
  input  wire logic              instr_start_i,
  input  wire logic [3:0]        instr_cycles_i,
  output tgd_pkg::tgd_mode_t     mode_o,
  output logic                   high_osc_run_o,
  output logic                   low_osc_run_o,
  output logic                   main_clk_tick_o,
  output logic [1:0]             machine_state_o,
  output logic                   cycle_end_o,
  output logic                   instr_busy_o,
  output logic                   instr_done_o,
  output logic                   divider_pulse_output_o,
  output tgd_pkg::tgd_taps_t     taps_o
);
  tgd_pkg::tgd_ctrl_t ctrl;
  tgd_pkg::tgd_mode_t mode;
  tgd_pkg::tgd_mode_t next_mode;
  tgd_pkg::tgd_mode_t resume;
  logic               from_high;
  logic               hi_on;
  logic               lo_on;
  logic               low_speed;
  logic               use_fs;
  logic               fc_tick;
  logic               fs_tick;
  logic               main_tick;
  logic               div_clear;
  logic               s6_carry;
  logic [STAGES-1:0]  stage;
  logic [1:0]         mstate;
  logic               cyc_end;
  logic [3:0]         left;
  logic               start_ok;

  // configuration held in flops; stage 7 select reads zero after reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctrl <= `TGD_CTRL_RST;
    end else begin
      ctrl <= ctrl_i;
    end
  end

  assign low_speed = (mode == tgd_pkg::low_speed_run_osc_on) || (mode == tgd_pkg::low_speed_run_osc_off) ||
                     (mode == tgd_pkg::low_speed_sleep_osc_on) || (mode == tgd_pkg::low_speed_sleep_osc_off);

  // oscillator enables per mode
  always_comb begin
    unique case (mode)
      tgd_pkg::high_speed_run_single: begin
        hi_on = 1'b1;
        lo_on = 1'b0;
      end
      tgd_pkg::high_speed_run_dual, tgd_pkg::low_speed_run_osc_on, tgd_pkg::low_speed_sleep_osc_on: begin
        hi_on = 1'b1;
        lo_on = 1'b1;
      end
      tgd_pkg::low_speed_run_osc_off, tgd_pkg::low_speed_sleep_osc_off: begin
        hi_on = 1'b0;
        lo_on = 1'b1;
      end
      tgd_pkg::stop_halt: begin
        hi_on = 1'b0;
        lo_on = 1'b0;
      end
      tgd_pkg::stop_warmup: begin
        hi_on = from_high;
        lo_on = (resume != tgd_pkg::high_speed_run_single);
      end
    endcase
  end

  tgd_edge_tick u_fc_tick (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .clk_lvl_i (high_freq_osc_in_i),
    .enable_i  (hi_on),
    .tick_o    (fc_tick)
  );

  tgd_edge_tick u_fs_tick (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .clk_lvl_i (low_freq_osc_in_i),
    .enable_i  (lo_on),
    .tick_o    (fs_tick)
  );

  // stage 7 source
  always_comb begin
    if (low_speed) begin
      use_fs = 1'b1;
    end else if (mode == tgd_pkg::stop_warmup) begin
      use_fs = ~from_high;
    end else begin
      use_fs = ctrl.seventh_stage_source_select;
    end
  end

  // mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      tgd_pkg::high_speed_run_single: begin
        if (stop_req_i) begin
          next_mode = tgd_pkg::stop_halt;
        end else if (ctrl.low_osc_en) begin
          next_mode = tgd_pkg::high_speed_run_dual;
        end
      end
      tgd_pkg::high_speed_run_dual: begin
        if (stop_req_i) begin
          next_mode = tgd_pkg::stop_halt;
        end else if (!ctrl.low_osc_en) begin
          next_mode = tgd_pkg::high_speed_run_single;
        end else if (ctrl.core_clock_source_select) begin
          next_mode = tgd_pkg::low_speed_run_osc_on;
        end
      end
      tgd_pkg::low_speed_run_osc_on: begin
        if (stop_req_i) begin
          next_mode = tgd_pkg::stop_halt;
        end else if (!ctrl.core_clock_source_select) begin
          next_mode = tgd_pkg::high_speed_run_dual;
        end else if (sleep_req_i) begin
          next_mode = tgd_pkg::low_speed_sleep_osc_on;
        end else if (!ctrl.high_osc_en) begin
          next_mode = tgd_pkg::low_speed_run_osc_off;
        end
      end
      tgd_pkg::low_speed_run_osc_off: begin
        if (stop_req_i) begin
          next_mode = tgd_pkg::stop_halt;
        end else if (sleep_req_i) begin
          next_mode = tgd_pkg::low_speed_sleep_osc_off;
        end else if (ctrl.high_osc_en) begin
          next_mode = tgd_pkg::low_speed_run_osc_on;
        end
      end
      tgd_pkg::low_speed_sleep_osc_on: begin
        if (wake_i) begin
          next_mode = tgd_pkg::low_speed_run_osc_on;
        end
      end
      tgd_pkg::low_speed_sleep_osc_off: begin
        if (wake_i) begin
          next_mode = tgd_pkg::low_speed_run_osc_off;
        end
      end
      tgd_pkg::stop_halt: begin
        if (stop_release_i) begin
          next_mode = tgd_pkg::stop_warmup;
        end
      end
      tgd_pkg::stop_warmup: begin
        if (stage[`TGD_WARMUP_TAP-1]) begin
          next_mode = resume;
        end
      end
    endcase
  end

  assign div_clear = (next_mode == tgd_pkg::stop_halt && mode != tgd_pkg::stop_halt) ||
                     (mode == tgd_pkg::stop_halt && stop_release_i);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mode <= tgd_pkg::high_speed_run_single;
    end else begin
      mode <= next_mode;
    end
  end

  // remember where STOP was entered from
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      resume    <= tgd_pkg::high_speed_run_single;
      from_high <= 1'b1;
    end else if (next_mode == tgd_pkg::stop_halt && mode != tgd_pkg::stop_halt) begin
      resume    <= mode;
      from_high <= ~low_speed;
    end
  end

  tgd_divider #(
    .STAGES (STAGES)
  ) u_div (
    .ref_clk_i  (ref_clk_i),
    .rstn_i     (rstn_i),
    .clear_i    (div_clear),
    .fc_tick_i  (fc_tick),
    .fs_tick_i  (fs_tick),
    .low_run_i  (hi_on),
    .use_fs_i   (use_fs),
    .stage_o    (stage),
    .s6_carry_o (s6_carry)
  );

  // main system clock
  assign main_tick = (mode == tgd_pkg::high_speed_run_single || mode == tgd_pkg::high_speed_run_dual) ?
                     fc_tick : (low_speed ? fs_tick : 1'b0);
  assign cyc_end   = main_tick && (mstate == `TGD_STATE_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mstate <= 2'h0;
    end else if (main_tick) begin
      mstate <= mstate + 1'b1;
    end
  end

  // instruction length, taken only when idle and in range
  assign start_ok = instr_start_i && !instr_busy_o &&
                    (instr_cycles_i >= `TGD_MIN_CYCLES) && (instr_cycles_i <= `TGD_MAX_CYCLES);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      left         <= 4'h0;
      instr_busy_o <= 1'b0;
      instr_done_o <= 1'b0;
    end else begin
      instr_done_o <= 1'b0;
      if (start_ok) begin
        left         <= instr_cycles_i;
        instr_busy_o <= 1'b1;
      end else if (instr_busy_o && cyc_end) begin
        left <= left - 1'b1;
        if (left == 4'h1) begin
          instr_busy_o <= 1'b0;
          instr_done_o <= 1'b1;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mode_o                 <= tgd_pkg::high_speed_run_single;
      high_osc_run_o         <= 1'b0;
      low_osc_run_o          <= 1'b0;
      main_clk_tick_o        <= 1'b0;
      machine_state_o        <= 2'h0;
      cycle_end_o            <= 1'b0;
      divider_pulse_output_o <= 1'b0;
      taps_o                 <= '0;
    end else begin
      mode_o                 <= mode;
      high_osc_run_o         <= hi_on;
      low_osc_run_o          <= lo_on;
      main_clk_tick_o        <= main_tick;
      machine_state_o        <= mstate;
      cycle_end_o            <= cyc_end;
      divider_pulse_output_o <= stage[`TGD_DVO_TAP-1];
      taps_o.timer_src       <= stage[`TGD_TMR_TAP-1];
      taps_o.time_base_src   <= stage[`TGD_TBT_TAP-1];
      taps_o.watchdog_src    <= stage[`TGD_WDT_TAP-1];
      taps_o.warmup_src      <= stage[`TGD_WARMUP_TAP-1];
    end
  end

  // checks
  logic [3:0] len_q;
  logic [3:0] ends_cnt;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      len_q    <= 4'h0;
      ends_cnt <= 4'h0;
    end else if (start_ok) begin
      len_q    <= instr_cycles_i;
      ends_cnt <= 4'h0;
    end else if (instr_busy_o && cyc_end) begin
      ends_cnt <= ends_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_STOP_CLEAR: assert property (
    mode == tgd_pkg::stop_halt && $past(mode) != tgd_pkg::stop_halt |-> stage == '0)
    else $error("divider not cleared on stop entry");
  AST_RELEASE_CLEAR: assert property (
    mode == tgd_pkg::stop_warmup && $past(mode) == tgd_pkg::stop_halt |-> stage == '0)
    else $error("divider not cleared on stop release");
  AST_SEL_S6: assert property (
    (mode == tgd_pkg::high_speed_run_dual && !ctrl.seventh_stage_source_select && !s6_carry && !div_clear)
    |=> $stable(stage[STAGES-1:`TGD_LOW_STAGES]))
    else $error("upper stages moved without stage 6 carry");
  AST_LOW_FS: assert property (
    (low_speed && fs_tick && !div_clear) |=>
    stage[STAGES-1:`TGD_LOW_STAGES] == $past(stage[STAGES-1:`TGD_LOW_STAGES]) + 1'b1)
    else $error("low clock not feeding stage 7 in low-speed mode");
  AST_WARM_S6: assert property (
    (mode == tgd_pkg::stop_warmup && from_high && !s6_carry && !div_clear)
    |=> $stable(stage[STAGES-1:`TGD_LOW_STAGES]))
    else $error("warm-up fed from wrong source");
  AST_STATE_STEP: assert property (
    main_tick |=> mstate == $past(mstate) + 2'h1 && main_clk_tick_o)
    else $error("machine state did not advance on main tick");
  AST_STATE_HOLD: assert property (
    !main_tick |=> $stable(mstate))
    else $error("machine state moved without main tick");
  AST_INSTR_LEN: assert property (
    instr_done_o |-> ends_cnt == len_q && len_q >= `TGD_MIN_CYCLES && len_q <= `TGD_MAX_CYCLES)
    else $error("instruction length mismatch");
  AST_SINGLE_FC: assert property (
    (mode == tgd_pkg::high_speed_run_single && fc_tick) |=> main_clk_tick_o)
    else $error("main tick missing in single clock mode");
  AST_CORE_SWITCH: assert property (
    (mode == tgd_pkg::high_speed_run_dual && ctrl.core_clock_source_select && ctrl.low_osc_en && !stop_req_i)
    |=> mode == tgd_pkg::low_speed_run_osc_on)
    else $error("core did not move to low clock");
  AST_STOP_OSC: assert property (
    mode == tgd_pkg::stop_halt |=> !high_osc_run_o && !low_osc_run_o)
    else $error("oscillator running in stop");
  AST_SEL_RESET: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    !rstn_i |=> !ctrl.seventh_stage_source_select)
    else $error("stage 7 select not zero after reset");

  COV_SLOW: cover property (mode == tgd_pkg::low_speed_run_osc_off);
  COV_WARM: cover property (mode == tgd_pkg::stop_warmup ##1 mode != tgd_pkg::stop_warmup);
  COV_LONG: cover property (instr_done_o && len_q == `TGD_MAX_CYCLES);
endmodule

// [dv/tgd_timing_gen_tb.sv]
`timescale 1ns/10ps
module testbench;
  localparam int LIMIT = 40000;
  logic                 ref_clk_i;
  logic                 rstn_i;
  logic                 high_freq_osc_in_i;
  logic                 low_freq_osc_in_i;
  tgd_pkg::tgd_ctrl_t   ctrl_i;
  logic                 stop_req_i;
  logic                 stop_release_i;
  logic                 sleep_req_i;
  logic                 wake_i;
  logic                 instr_start_i;
  logic [3:0]           instr_cycles_i;
  tgd_pkg::tgd_mode_t   mode_o;
  logic                 high_osc_run_o;
  logic                 low_osc_run_o;
  logic                 main_clk_tick_o;
  logic [1:0]           machine_state_o;
  logic                 cycle_end_o;
  logic                 instr_busy_o;
  logic                 instr_done_o;
  logic                 divider_pulse_output_o;
  tgd_pkg::tgd_taps_t   taps_o;
  int                   err_count;
  int                   n_compared;
  int                   cyc;
  int                   osc_cnt;
  int                   ticks;
  int                   ends_seen;

  tgd_timing_gen dut_u (
    .ref_clk_i              (ref_clk_i),
    .rstn_i                 (rstn_i),
    .high_freq_osc_in_i     (high_freq_osc_in_i),
    .low_freq_osc_in_i      (low_freq_osc_in_i),
    .ctrl_i                 (ctrl_i),
    .stop_req_i             (stop_req_i),
    .stop_release_i         (stop_release_i),
    .sleep_req_i            (sleep_req_i),
    .wake_i                 (wake_i),
    .instr_start_i          (instr_start_i),
    .instr_cycles_i         (instr_cycles_i),
    .mode_o                 (mode_o),
    .high_osc_run_o         (high_osc_run_o),
    .low_osc_run_o          (low_osc_run_o),
    .main_clk_tick_o        (main_clk_tick_o),
    .machine_state_o        (machine_state_o),
    .cycle_end_o            (cycle_end_o),
    .instr_busy_o           (instr_busy_o),
    .instr_done_o           (instr_done_o),
    .divider_pulse_output_o (divider_pulse_output_o),
    .taps_o                 (taps_o)
  );

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] expv, input logic [15:0] got);
    n_compared++;
    if (got !== expv) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", nm, expv, got);
    end
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // fc toggles every 2 cycles (period 4), fs every 8 cycles (period 16)
  always @(posedge ref_clk_i) begin
    #1;
    osc_cnt = osc_cnt + 1;
    if (osc_cnt % 2 == 0) high_freq_osc_in_i = ~high_freq_osc_in_i;
    if (osc_cnt % 8 == 0) low_freq_osc_in_i = ~low_freq_osc_in_i;
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      stop_test();
    end
  end

  // every machine cycle spans four main clock ticks
  always @(negedge ref_clk_i) begin
    if (rstn_i === 1'b1) begin
      if (mode_o == tgd_pkg::stop_halt || mode_o == tgd_pkg::stop_warmup) begin
        ends_seen = 0;
        ticks = 0;
      end
      if (main_clk_tick_o === 1'b1) ticks++;
      if (cycle_end_o === 1'b1) begin
        if (ends_seen > 0) check("ticks per machine cycle", 16'h4, ticks[15:0]);
        ends_seen++;
        ticks = 0;
      end
    end
  end

  task automatic set_ctrl(input logic [3:0] v);
    @(posedge ref_clk_i);
    #1 ctrl_i = tgd_pkg::tgd_ctrl_t'(v);
  endtask

  task automatic pulse(ref logic s);
    @(posedge ref_clk_i);
    #1 s = 1'b1;
    @(posedge ref_clk_i);
    #1 s = 1'b0;
  endtask

  task automatic wait_mode(input tgd_pkg::tgd_mode_t m, input int lim, input string nm);
    int k;
    for (k = 0; k < lim && mode_o !== m; k++) @(negedge ref_clk_i);
    check(nm, 16'(m), 16'(mode_o));
  endtask

  task automatic tick_gap(input int expv, input string nm);
    int t0;
    int k;
    t0 = -1;
    repeat (40) @(negedge ref_clk_i);
    for (k = 0; k < 100; k++) begin
      @(negedge ref_clk_i);
      if (main_clk_tick_o === 1'b1) begin
        if (t0 >= 0) break;
        t0 = cyc;
      end
    end
    check(nm, 16'(expv), 16'(cyc - t0));
  endtask

  // cycles between two toggles of the divider pulse output
  task automatic dvo_gap(input int expv, input string nm);
    int   t0;
    int   k;
    logic v;
    t0 = -1;
    repeat (3) @(negedge ref_clk_i);
    v = divider_pulse_output_o;
    for (k = 0; k < 2200; k++) begin
      @(negedge ref_clk_i);
      if (divider_pulse_output_o !== v) begin
        v = divider_pulse_output_o;
        if (t0 >= 0) break;
        t0 = cyc;
      end
    end
    check(nm, 16'(expv), 16'(cyc - t0));
  endtask

  // start just after a machine cycle ends so the count is unambiguous
  task automatic run_instr(input logic [3:0] n);
    int k;
    int ends;
    for (k = 0; k < 200 && cycle_end_o !== 1'b1; k++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    #1 instr_cycles_i = n;
    instr_start_i = 1'b1;
    @(posedge ref_clk_i);
    #1 instr_start_i = 1'b0;
    ends = 0;
    if (n == 4'h0 || n > 4'hA) begin
      repeat (3) @(negedge ref_clk_i);
      check("busy after refused start", 16'h0, 16'(instr_busy_o));
    end else begin
      for (k = 0; k < 800; k++) begin
        @(negedge ref_clk_i);
        if (cycle_end_o === 1'b1) ends++;
        if (instr_done_o === 1'b1) break;
      end
      check("instruction done", 16'h1, 16'(instr_done_o));
      check("machine cycles per instruction", 16'(n), 16'(ends));
      check("busy at done", 16'h0, 16'(instr_busy_o));
    end
  endtask

  initial begin
    int i;
    int k;
    int nt;
    tgd_pkg::tgd_mode_t before_stop;
    rstn_i = 1'b0;
    high_freq_osc_in_i = 1'b0;
    low_freq_osc_in_i = 1'b0;
    ctrl_i = tgd_pkg::tgd_ctrl_t'(4'h8);
    stop_req_i = 1'b0;
    stop_release_i = 1'b0;
    sleep_req_i = 1'b0;
    wake_i = 1'b0;
    instr_start_i = 1'b0;
    instr_cycles_i = 4'h1;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    osc_cnt = 0;
    ticks = 0;
    ends_seen = 0;
    void'($urandom(32'h371C));
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("mode in reset", 16'(tgd_pkg::high_speed_run_single), 16'(mode_o));
    check("taps in reset", 16'h0, 16'({taps_o, divider_pulse_output_o, main_clk_tick_o}));
    @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    check("high osc run after reset", 16'h1, 16'(high_osc_run_o));
    tick_gap(4, "single mode tick gap");
    for (k = 0; k < 300 && taps_o.timer_src !== 1'b1; k++) @(negedge ref_clk_i);
    check("timer tap toggles", 16'h1, 16'(taps_o.timer_src));
    run_instr(4'h1);
    run_instr(4'hA);
    run_instr(4'h0);
    run_instr(4'hB);
    for (i = 0; i < 6; i++) run_instr(4'($urandom_range(10, 1)));
    set_ctrl(4'hC);
    wait_mode(tgd_pkg::high_speed_run_dual, 12, "enter dual");
    check("low osc run in dual", 16'h1, 16'(low_osc_run_o));
    tick_gap(4, "dual mode tick gap");
    set_ctrl(4'hD);
    // low clock every 16 cycles; stage 13 toggles every 64 stage 7 inputs
    dvo_gap(16 * 64, "divider pulse half period on low path");
    set_ctrl(4'hF);
    wait_mode(tgd_pkg::low_speed_run_osc_on, 12, "core select to low");
    tick_gap(16, "slow mode tick gap");
    run_instr(4'($urandom_range(10, 1)));
    set_ctrl(4'h6);
    wait_mode(tgd_pkg::low_speed_run_osc_off, 12, "high osc off");
    repeat (3) @(negedge ref_clk_i);
    check("high osc stopped", 16'h0, 16'(high_osc_run_o));
    pulse(sleep_req_i);
    wait_mode(tgd_pkg::low_speed_sleep_osc_off, 12, "enter sleep");
    tick_gap(16, "sleep mode tick gap");
    pulse(wake_i);
    wait_mode(tgd_pkg::low_speed_run_osc_off, 12, "leave sleep");
    set_ctrl(4'hE);
    wait_mode(tgd_pkg::low_speed_run_osc_on, 12, "high osc back on");
    set_ctrl(4'hC);
    wait_mode(tgd_pkg::high_speed_run_dual, 12, "core select to high");
    set_ctrl(4'hE);
    wait_mode(tgd_pkg::low_speed_run_osc_on, 12, "slow before stop");
    before_stop = mode_o;
    repeat (200) @(negedge ref_clk_i);
    pulse(stop_req_i);
    wait_mode(tgd_pkg::stop_halt, 12, "enter stop");
    repeat (3) @(negedge ref_clk_i);
    check("divider cleared on stop", 16'h0, 16'({taps_o, divider_pulse_output_o}));
    nt = 0;
    for (k = 0; k < 60; k++) begin
      @(negedge ref_clk_i);
      if (main_clk_tick_o === 1'b1) nt++;
    end
    check("no main ticks in stop", 16'h0, 16'(nt));
    pulse(stop_release_i);
    wait_mode(tgd_pkg::stop_warmup, 12, "warm-up after release");
    wait_mode(before_stop, 12000, "return after warm-up");
    tick_gap(16, "tick gap after stop");
    set_ctrl(4'hC);
    wait_mode(tgd_pkg::high_speed_run_dual, 12, "dual before second stop");
    pulse(stop_req_i);
    wait_mode(tgd_pkg::stop_halt, 12, "stop from high speed");
    pulse(stop_release_i);
    wait_mode(tgd_pkg::stop_warmup, 12, "warm-up from high speed");
    // stage 6 carries once per 1024 cycles; the low clock would have set stage 13 by now
    repeat (1200) @(negedge ref_clk_i);
    check("still warming from stage 6", 16'(tgd_pkg::stop_warmup), 16'(mode_o));
    check("divider pulse in warm-up", 16'h0, 16'(divider_pulse_output_o));
    // reset in mid-run, from inside warm-up
    @(posedge ref_clk_i);
    #1 rstn_i = 1'b0;
    ctrl_i = tgd_pkg::tgd_ctrl_t'(4'h8);
    repeat (3) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    @(negedge ref_clk_i);
    check("divider cleared by reset", 16'h0, 16'({taps_o, divider_pulse_output_o}));
    check("mode after mid-run reset", 16'(tgd_pkg::high_speed_run_single), 16'(mode_o));
    repeat (2) @(negedge ref_clk_i);
    check("low osc off after reset", 16'h0, 16'(low_osc_run_o));
    tick_gap(4, "single tick gap after reset");
    stop_test();
  end
endmodule
